// ==== inc/tali_defs.svh ====
// Constants for the two-axis linear interpolation sequencer
`ifndef TALI_DEFS_SVH
`define TALI_DEFS_SVH
`define TALI_DEPTH 511
`define TALI_EXTENT_MAX 32'h7FFFFFFF
`define TALI_SCALE_ONE 17'h02710
`define TALI_SCALE_MAX 17'h186A0
`define TALI_SERVO_PERIOD_NS 25000
`define TALI_CLK_NS 25
`define TALI_TICK_CYC ((`TALI_SERVO_PERIOD_NS + `TALI_CLK_NS - 1) / `TALI_CLK_NS)
`define TALI_A_CTRL 5'h00
`define TALI_A_AXES 5'h01
`define TALI_A_SEGA 5'h02
`define TALI_A_SEGB 5'h03
`define TALI_A_SEGSPD 5'h04
`define TALI_A_PUSH 5'h05
`define TALI_A_SPEED 5'h06
`define TALI_A_ACCEL 5'h07
`define TALI_A_DECEL 5'h08
`define TALI_A_SCALE 5'h09
`define TALI_A_SMOOTH 5'h0A
`define TALI_A_TRIPD 5'h0B
`define TALI_A_FREE 5'h10
`define TALI_A_SEGCNT 5'h11
`define TALI_A_EXTENT 5'h12
`define TALI_A_TRAV 5'h13
`define TALI_A_STATUS 5'h14
`define TALI_A_VEL 5'h15
`define TALI_A_VELA 5'h16
`define TALI_A_VELB 5'h17
`define TALI_C_LAUNCH 0
`define TALI_C_TERM 1
`define TALI_C_PURGE 2
`define TALI_C_HALT 3
`define TALI_C_KILL 4
`define TALI_C_KILLM 5
`define TALI_C_RUNPG 6
`define TALI_P_SSTART 0
`define TALI_P_SEND 1
`define TALI_AXES_RST 4'h3
`endif

// ==== inc/tali_pkg.sv ====
// Types for the two-axis linear interpolation sequencer
package tali_pkg;
  typedef struct packed {
    logic signed [31:0] inc_a;
    logic signed [31:0] inc_b;
    logic [31:0] len;
    logic [31:0] v_start;
    logic [31:0] v_end;
    logic has_start;
    logic has_end;
  } tali_seg_s;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RUN,
    ST_RAMP_STOP
  } tali_state_e;
endpackage

// ==== logic/tali_seq.sv ====
// Two-axis linear interpolation sequencer with bus-facing register port
`timescale 1ns/1ps
`include "tali_defs.svh"
module tali_seq #(
  parameter int DEPTH = `TALI_DEPTH,
  parameter int TICK_CYC = `TALI_TICK_CYC
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Register port
  input wire logic [4:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Axis outputs
  output logic signed [31:0] o_pos_a,
  output logic signed [31:0] o_pos_b,
  output logic o_moving,
  output logic o_program_run,
  output logic o_program_hold
);
  localparam int AW = $clog2(DEPTH + 1);
  initial begin
    if (DEPTH < 2 || DEPTH > 4095) $error("DEPTH out of range");
    if (TICK_CYC < 1) $error("TICK_CYC too small");
  end

  tali_pkg::tali_seg_s mem [DEPTH];
  tali_pkg::tali_seg_s stage;
  tali_pkg::tali_seg_s cur;
  tali_pkg::tali_state_e state;
  logic [AW-1:0] wptr, rptr, count;
  logic [3:0] axes;
  logic [31:0] speed, accel, decel, smooth, trip_d;
  logic [16:0] scale;
  logic [31:0] vel, vel_f, target, end_target;
  logic end_pending;
  logic term_seen, have_cur, prog_run, trip_d_on, trip_s_on;
  logic [31:0] seg_done, seg_cnt, extent, trav;
  logic signed [31:0] base_a, base_b, pos_a, pos_b;
  logic [31:0] tick_cnt;
  logic [31:0] vel_a, vel_b;

  // Register decode
  wire wr_ctrl = i_wr && i_addr == `TALI_A_CTRL;
  wire do_launch = wr_ctrl && i_wdata[`TALI_C_LAUNCH];
  wire do_term = wr_ctrl && i_wdata[`TALI_C_TERM];
  wire do_purge = wr_ctrl && i_wdata[`TALI_C_PURGE] && state == tali_pkg::ST_IDLE;
  wire do_halt = wr_ctrl && i_wdata[`TALI_C_HALT];
  wire do_kill = wr_ctrl && i_wdata[`TALI_C_KILL];
  wire do_killm = wr_ctrl && i_wdata[`TALI_C_KILLM];
  wire do_runpg = wr_ctrl && i_wdata[`TALI_C_RUNPG];
  wire full = count == AW'(DEPTH);
  wire do_push = i_wr && i_addr == `TALI_A_PUSH && !full;
  wire tick = tick_cnt == 32'(TICK_CYC - 1);

  // Vector length of a segment by integer square root of the sum of squares
  function automatic logic [31:0] isqrt(input logic [63:0] v);
    logic [63:0] r;
    logic [63:0] b;
    r = 64'h0;
    b = 64'h4000000000000000;
    for (int k = 0; k < 32; k++) begin
      if (v >= r + b) begin
        v = v - (r + b);
        r = (r >> 1) + b;
      end else begin
        r = r >> 1;
      end
      b = b >> 2;
    end
    return r[31:0];
  endfunction

  function automatic logic [31:0] absv(input logic signed [31:0] x);
    return x[31] ? 32'(-x) : 32'(x);
  endfunction

  wire [31:0] abs_a = absv(stage.inc_a);
  wire [31:0] abs_b = absv(stage.inc_b);
  wire [63:0] sq_sum = 64'(abs_a) * 64'(abs_a) + 64'(abs_b) * 64'(abs_b);
  wire [31:0] stage_len = isqrt(sq_sum);

  // Feed-scaled commanded speed; accelerations stay unscaled
  wire [48:0] scaled = 49'(target) * 49'(scale);
  wire [31:0] vel_cmd = 32'(scaled / 49'(`TALI_SCALE_ONE));
  wire [31:0] remain = have_cur ? (cur.len - seg_done) : 32'h0;
  wire [31:0] goal_v = end_pending ? end_target : 32'h0;
  wire [63:0] dv = (vel > goal_v) ? 64'(vel - goal_v) : 64'h0;
  wire [63:0] brake_d = (decel == 32'h0) ? 64'h0 : (dv * 64'(vel + goal_v)) / (64'(decel) << 1);
  wire want_brake = (term_seen && count == '0) || end_pending;
  wire brake = want_brake && brake_d >= 64'(remain);
  wire [31:0] s_step = (smooth == 32'h0) ? accel : (accel / (smooth + 32'h1));
  wire [31:0] up_v = (vel_cmd - vel > s_step) ? vel + s_step : vel_cmd;
  wire [31:0] dn_lim = brake ? goal_v : vel_cmd;
  wire [31:0] dn_v = (vel - dn_lim > decel) ? vel - decel : dn_lim;
  wire [31:0] ramp_v = (state == tali_pkg::ST_RAMP_STOP) ? ((vel > decel) ? vel - decel : 32'h0)
                     : (brake || vel > vel_cmd) ? dn_v : up_v;
  wire [31:0] step_d = (ramp_v < 32'h1 && state == tali_pkg::ST_RUN && want_brake) ? 32'h1 : ramp_v;
  wire seg_end = have_cur && seg_done + step_d >= cur.len;
  wire [31:0] move_d = seg_end ? remain : step_d;
  // Signed interpolation so that negative increments divide correctly
  wire signed [63:0] done_s = $signed({32'h0, seg_done + move_d});
  wire signed [63:0] len_s = $signed({32'h0, cur.len});
  wire signed [63:0] pa = (cur.len == 32'h0) ? 64'sh0 :
                          64'($signed(cur.inc_a)) * done_s / len_s;
  wire signed [63:0] pb = (cur.len == 32'h0) ? 64'sh0 :
                          64'($signed(cur.inc_b)) * done_s / len_s;
  wire [32:0] ext_sum = 33'(extent) + 33'(stage_len);
  wire [31:0] next_extent = (ext_sum > 33'(`TALI_EXTENT_MAX)) ? 32'h0 : ext_sum[31:0];
  wire mem_avail = count != '0;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      tick_cnt <= 32'h0;
    end else begin
      tick_cnt <= tick ? 32'h0 : tick_cnt + 32'h1;
    end
  end

  // Register writes and buffer fill
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      axes <= `TALI_AXES_RST;
      stage <= '0;
      speed <= 32'h0;
      accel <= 32'h0;
      decel <= 32'h0;
      scale <= `TALI_SCALE_ONE;
      smooth <= 32'h0;
      trip_d <= 32'h0;
      wptr <= '0;
      extent <= 32'h0;
    end else begin
      if (i_wr) begin
        case (i_addr)
          `TALI_A_AXES: axes <= i_wdata[3:0];
          `TALI_A_SEGA: stage.inc_a <= i_wdata;
          `TALI_A_SEGB: stage.inc_b <= i_wdata;
          `TALI_A_SEGSPD: begin
            stage.has_start <= i_wdata[`TALI_P_SSTART];
            stage.has_end <= i_wdata[`TALI_P_SEND];
            stage.v_start <= {16'h0, i_wdata[31:16]};
            stage.v_end <= {16'h0, i_wdata[31:16]};
          end
          `TALI_A_SPEED: speed <= i_wdata;
          `TALI_A_ACCEL: accel <= i_wdata;
          `TALI_A_DECEL: decel <= i_wdata;
          `TALI_A_SCALE: scale <= (i_wdata[16:0] > `TALI_SCALE_MAX) ? `TALI_SCALE_MAX
                                  : i_wdata[16:0];
          `TALI_A_SMOOTH: smooth <= i_wdata;
          `TALI_A_TRIPD: trip_d <= i_wdata;
          default: ;
        endcase
      end
      if (do_push) begin
        mem[wptr] <= '{inc_a: stage.inc_a, inc_b: stage.inc_b, len: stage_len,
                       v_start: stage.v_start, v_end: stage.v_end,
                       has_start: stage.has_start, has_end: stage.has_end};
        wptr <= (wptr == AW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
        extent <= next_extent;
        stage.has_start <= 1'b0;
        stage.has_end <= 1'b0;
      end
      if (do_purge) begin
        wptr <= rptr;
        extent <= 32'h0;
      end
    end
  end

  // Motion engine, advanced once per servo tick
  wire pop = tick && state != tali_pkg::ST_IDLE && (!have_cur || seg_end) && mem_avail;
  wire [AW-1:0] next_count = count + AW'(do_push) - AW'(pop);

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state <= tali_pkg::ST_IDLE;
      rptr <= '0;
      count <= '0;
      cur <= '0;
      have_cur <= 1'b0;
      vel <= 32'h0;
      target <= 32'h0;
      end_target <= 32'h0;
      end_pending <= 1'b0;
      term_seen <= 1'b0;
      seg_done <= 32'h0;
      seg_cnt <= 32'h0;
      trav <= 32'h0;
      base_a <= 32'sh0;
      base_b <= 32'sh0;
      pos_a <= 32'sh0;
      pos_b <= 32'sh0;
      prog_run <= 1'b1;
      trip_d_on <= 1'b0;
      trip_s_on <= 1'b0;
    end else begin
      count <= do_purge ? '0 : next_count;
      if (i_wr && i_addr == `TALI_A_SPEED) target <= i_wdata;
      if (do_term) term_seen <= 1'b1;
      if (do_runpg) prog_run <= 1'b1;
      if (trip_d_on && trav >= trip_d) trip_d_on <= 1'b0;
      if (trip_s_on && state == tali_pkg::ST_IDLE) trip_s_on <= 1'b0;
      // Arming wins over a release in the same cycle
      if (i_wr && i_addr == `TALI_A_TRIPD) trip_d_on <= 1'b1;
      if (wr_ctrl && i_wdata[`TALI_C_TERM + 6]) trip_s_on <= 1'b1;
      if (do_launch && state == tali_pkg::ST_IDLE) begin
        state <= tali_pkg::ST_RUN;
        seg_cnt <= 32'h0;
        trav <= 32'h0;
        if (!(i_wr && i_addr == `TALI_A_SPEED)) target <= speed;
      end
      if (do_halt && state == tali_pkg::ST_RUN) state <= tali_pkg::ST_RAMP_STOP;
      if (tick && state != tali_pkg::ST_IDLE) begin
        vel <= ramp_v;
        if (have_cur) begin
          pos_a <= base_a + 32'(pa);
          pos_b <= base_b + 32'(pb);
          trav <= trav + move_d;
          seg_done <= seg_end ? 32'h0 : seg_done + move_d;
          if (seg_end) begin
            base_a <= base_a + cur.inc_a;
            base_b <= base_b + cur.inc_b;
            have_cur <= 1'b0;
            seg_cnt <= seg_cnt + 32'h1;
            if (end_pending) end_pending <= 1'b0;
          end
        end
        if (pop) begin
          cur <= mem[rptr];
          have_cur <= 1'b1;
          rptr <= (rptr == AW'(DEPTH - 1)) ? '0 : rptr + 1'b1;
          if (mem[rptr].has_start) target <= mem[rptr].v_start;
          if (mem[rptr].has_end && !end_pending) begin
            end_pending <= 1'b1;
            end_target <= mem[rptr].v_end;
          end
        end else if ((!have_cur || seg_end) && !mem_avail) begin
          state <= tali_pkg::ST_IDLE;
          vel <= 32'h0;
          term_seen <= 1'b0;
        end
        if (state == tali_pkg::ST_RAMP_STOP && ramp_v == 32'h0) begin
          state <= tali_pkg::ST_IDLE;
          term_seen <= 1'b0;
        end
      end
      if (do_kill || do_killm) begin
        state <= tali_pkg::ST_IDLE;
        vel <= 32'h0;
        have_cur <= 1'b0;
        seg_done <= 32'h0;
        end_pending <= 1'b0;
        term_seen <= 1'b0;
        if (do_kill) prog_run <= 1'b0;
      end
    end
  end

  // Per-axis speed split along the current direction
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      vel_a <= 32'h0;
      vel_b <= 32'h0;
    end else if (have_cur && cur.len != 32'h0) begin
      vel_a <= 32'(64'(vel) * 64'(absv(cur.inc_a)) / 64'(cur.len));
      vel_b <= 32'(64'(vel) * 64'(absv(cur.inc_b)) / 64'(cur.len));
    end else begin
      vel_a <= 32'h0;
      vel_b <= 32'h0;
    end
  end

  // Read mux, data valid one cycle after the strobe
  wire [31:0] status_w = {27'h0, term_seen, end_pending, have_cur, state};
  logic [31:0] rd_mux;
  always_comb begin
    case (i_addr)
      `TALI_A_AXES: rd_mux = {28'h0, axes};
      `TALI_A_SPEED: rd_mux = speed;
      `TALI_A_ACCEL: rd_mux = accel;
      `TALI_A_DECEL: rd_mux = decel;
      `TALI_A_SCALE: rd_mux = {15'h0, scale};
      `TALI_A_SMOOTH: rd_mux = smooth;
      `TALI_A_TRIPD: rd_mux = trip_d;
      `TALI_A_FREE: rd_mux = 32'(AW'(DEPTH) - count);
      `TALI_A_SEGCNT: rd_mux = seg_cnt;
      `TALI_A_EXTENT: rd_mux = extent;
      `TALI_A_TRAV: rd_mux = trav;
      `TALI_A_STATUS: rd_mux = status_w;
      `TALI_A_VEL: rd_mux = vel;
      `TALI_A_VELA: rd_mux = vel_a;
      `TALI_A_VELB: rd_mux = vel_b;
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 32'h0;
      o_pos_a <= 32'sh0;
      o_pos_b <= 32'sh0;
      o_moving <= 1'b0;
      o_program_run <= 1'b1;
      o_program_hold <= 1'b0;
    end else begin
      o_rdata <= i_rd ? rd_mux : 32'h0;
      o_pos_a <= pos_a;
      o_pos_b <= pos_b;
      o_moving <= state != tali_pkg::ST_IDLE;
      o_program_run <= prog_run;
      o_program_hold <= trip_d_on || trip_s_on;
    end
  end
endmodule

// ==== sim/tali_seq_sva.sv ====
// Concurrent checks on the sequencer register port and motion outputs
`timescale 1ns/1ps
`include "tali_defs.svh"
module tali_seq_sva #(
  parameter int DEPTH = 511,
  parameter int TICK_CYC = 1000
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Register port
  input wire logic [4:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  // Motion outputs
  input wire logic signed [31:0] o_pos_a,
  input wire logic signed [31:0] o_pos_b,
  input wire logic o_moving,
  input wire logic o_program_run,
  input wire logic o_program_hold
);
  wire ctrl_wr = i_wr && (i_addr == `TALI_A_CTRL);
  default clocking @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);
  a_kill_stops:
    assert property (ctrl_wr && i_wdata[4] |-> ##2 !o_moving && !o_program_run)
    else $error("kill left motion or program running");
  a_kill_motion:
    assert property (ctrl_wr && i_wdata[7:0] == 8'h20 |->
      ##2 !o_moving && o_program_run == $past(o_program_run))
    else $error("motion-only kill misbehaved");
  a_resume_run:
    assert property (ctrl_wr && i_wdata[7:0] == 8'h40 |-> ##2 o_program_run)
    else $error("program did not resume");
  a_idle_frozen:
    assert property (!o_moving && !$past(o_moving) |-> $stable(o_pos_a) && $stable(o_pos_b))
    else $error("position moved while idle");
  a_free_range:
    assert property ($past(i_rd) && $past(i_addr) == `TALI_A_FREE |-> o_rdata <= DEPTH)
    else $error("free count above depth");
  a_extent_range:
    assert property ($past(i_rd) && $past(i_addr) == `TALI_A_EXTENT |-> o_rdata[31] == 1'b0)
    else $error("path extent beyond wrap point");
  a_hold_seq:
    assert property (ctrl_wr && i_wdata[7:0] == 8'h80 && o_moving |-> ##2 o_program_hold)
    else $error("sequence wait not holding program");
  a_rdata_idle:
    assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside read slot");
endmodule
bind tali_seq tali_seq_sva #(.DEPTH(DEPTH), .TICK_CYC(TICK_CYC)) tali_seq_sva_inst (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .o_pos_a(o_pos_a), .o_pos_b(o_pos_b),
  .o_moving(o_moving), .o_program_run(o_program_run), .o_program_hold(o_program_hold));

// ==== sim/tali_host.sv ====
// Host model driving the sequencer register port
`timescale 1ns/1ps
`include "tali_defs.svh"
module tali_host (
  // Clock and read data
  input wire logic i_mclk,
  input wire logic [31:0] i_rdata,
  // Request
  output logic [4:0] o_addr,
  output logic [31:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  initial begin
    o_addr = 5'h00;
    o_wdata = 32'h0;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    o_rd <= 1'b0;
    @(posedge i_mclk);
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    o_addr <= a;
    o_wr <= 1'b0;
    o_rd <= 1'b1;
    @(posedge i_mclk);
    o_rd <= 1'b0;
    o_wdata <= $urandom;
    @(posedge i_mclk);
    d = i_rdata;
  endtask
  task automatic idle(input int n);
    o_wr <= 1'b0;
    o_rd <= 1'b0;
    repeat (n) @(posedge i_mclk);
  endtask
  task automatic push(input logic [31:0] a, input logic [31:0] b);
    logic [31:0] f;
    rd(`TALI_A_FREE, f);
    if (f != 32'h0) begin
      wr(`TALI_A_SEGA, a);
      wr(`TALI_A_SEGB, b);
      wr(`TALI_A_PUSH, 32'h0);
    end
  endtask
endmodule

// ==== sim/tali_seq_tb.sv ====
// Self-checking bench for the two-axis sequencer
`timescale 1ns/1ps
`include "tali_defs.svh"
module tali_seq_tb;
  localparam int DEPTH = 511;
  logic i_mclk, i_rst;
  wire i_wr, i_rd;
  wire [4:0] i_addr;
  wire [31:0] i_wdata, o_rdata;
  wire signed [31:0] o_pos_a, o_pos_b;
  wire o_moving, o_program_run, o_program_hold;
  int n_fail = 0, n_checks = 0, exp_a = 0, exp_b = 0;
  longint ext = 0;
  int lens[$];
  tali_seq #(.DEPTH(DEPTH), .TICK_CYC(4)) tali_seq_inst (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_pos_a(o_pos_a), .o_pos_b(o_pos_b),
    .o_moving(o_moving), .o_program_run(o_program_run), .o_program_hold(o_program_hold));
  tali_host h (.i_mclk(i_mclk), .i_rdata(o_rdata), .o_addr(i_addr), .o_wdata(i_wdata),
    .o_wr(i_wr), .o_rd(i_rd));
  initial begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end
  task automatic test_done();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] d;
    h.rd(a, d);
    check(d, exp);
  endtask
  task automatic seg(input int k, input int sa, input int sb);
    h.push(32'(sa * 3 * k), 32'(sb * 4 * k));
    exp_a += sa * 3 * k;
    exp_b += sb * 4 * k;
    lens.push_back(5 * k);
    ext += 5 * k;
    ext = (ext > 64'h7FFFFFFF) ? 0 : ext;
  endtask
  function automatic int sg();
    return ($urandom_range(1, 0) == 0) ? -1 : 1;
  endfunction
  task automatic wait_stop();
    int i;
    for (i = 0; i < 20000 && o_moving !== 1'b0; i++)
      @(posedge i_mclk);
    if (i == 20000) begin
      n_fail++;
      test_done();
    end
  endtask
  // Random path, optional terminator, sequence wait armed
  task automatic run(input bit term);
    repeat (6) seg($urandom_range(20, 1), sg(), sg());
    rdc(`TALI_A_FREE, 32'(DEPTH - lens.size()));
    if (term) h.wr(`TALI_A_CTRL, 32'h2);
    h.wr(`TALI_A_CTRL, 32'h1);
    h.idle(2);
    h.wr(`TALI_A_CTRL, 32'h80);
    h.idle(2);
    check(o_program_hold, 1'b1);
    wait_stop();
    h.idle(2);
    check(o_program_hold, 1'b0);
    check(o_pos_a, exp_a);
    check(o_pos_b, exp_b);
    rdc(`TALI_A_FREE, 32'(DEPTH));
    rdc(`TALI_A_SEGCNT, 32'd6);
    rdc(`TALI_A_TRAV, 32'(lens.sum()));
    lens.delete();
  endtask
  initial begin
    void'($urandom(96880));
    i_rst = 1'b1;
    repeat (16) @(posedge i_mclk);
    i_rst <= 1'b0;
    h.idle(1);
    rdc(`TALI_A_FREE, 32'(DEPTH));
    rdc(`TALI_A_SEGCNT, 32'h0);
    rdc(5'h1F, 32'h0);
    check(o_program_run, 1'b1);
    seg(300000000, 1, 1);
    rdc(`TALI_A_EXTENT, 32'(ext));
    seg(300000000, 1, -1);
    rdc(`TALI_A_EXTENT, 32'(ext));
    rdc(`TALI_A_FREE, 32'(DEPTH - lens.size()));
    h.wr(`TALI_A_CTRL, 32'h4);
    lens.delete();
    exp_a = 0;
    exp_b = 0;
    ext = 0;
    rdc(`TALI_A_FREE, 32'(DEPTH));
    rdc(`TALI_A_EXTENT, 32'h0);
    h.wr(`TALI_A_SEGA, 32'h1);
    h.wr(`TALI_A_SEGB, 32'h0);
    repeat (DEPTH) h.wr(`TALI_A_PUSH, 32'h0);
    rdc(`TALI_A_FREE, 32'h0);
    h.wr(`TALI_A_PUSH, 32'h0);
    rdc(`TALI_A_FREE, 32'h0);
    h.wr(`TALI_A_CTRL, 32'h4);
    h.wr(`TALI_A_SPEED, 32'd50);
    h.wr(`TALI_A_ACCEL, 32'd10);
    h.wr(`TALI_A_DECEL, 32'd10);
    run(1'b1);
    run(1'b0);
    // Long move: speed split, feed scale, ramped halt
    seg(2000, 1, 1);
    h.wr(`TALI_A_CTRL, 32'h2);
    h.wr(`TALI_A_CTRL, 32'h1);
    h.wr(`TALI_A_TRIPD, 32'd100);
    h.idle(2);
    check(o_program_hold, 1'b1);
    h.idle(118);
    check(o_program_hold, 1'b0);
    rdc(`TALI_A_VEL, 32'd50);
    rdc(`TALI_A_VELA, 32'd30);
    rdc(`TALI_A_VELB, 32'd40);
    h.wr(`TALI_A_SCALE, 32'd5000);
    h.idle(40);
    rdc(`TALI_A_VEL, 32'd25);
    h.wr(`TALI_A_CTRL, 32'h8);
    h.idle(2);
    check(o_moving, 1'b1);
    wait_stop();
    check(32'(o_pos_a < exp_a), 32'h1);
    h.wr(`TALI_A_SCALE, 32'd10000);
    seg(2000, 1, 1);
    h.wr(`TALI_A_CTRL, 32'h1);
    h.idle(20);
    h.wr(`TALI_A_CTRL, 32'h20);
    h.idle(2);
    check(o_moving, 1'b0);
    check(o_program_run, 1'b1);
    h.wr(`TALI_A_CTRL, 32'h10);
    h.idle(2);
    check(o_program_run, 1'b0);
    h.wr(`TALI_A_CTRL, 32'h40);
    h.idle(2);
    check(o_program_run, 1'b1);
    test_done();
  end
endmodule
